// File: core/fifo_flags_pkg.sv
// Constants and types shared by the FIFO status-flag bank
package fifo_flags_pkg;
  localparam int DEPTH = 256;
  localparam int ADDR_W = 8;
  localparam int PTR_W = 9;
  localparam int DATA_W = 18;
  localparam int OFFS_W = 12;
  localparam int CNT_W = 13;
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;

  localparam logic [OFFS_W-1:0] EMPTY_OFFS_RST = 12'h01f;
  localparam logic [OFFS_W-1:0] FULL_OFFS_RST = 12'h01f;
  localparam logic [CNT_W-1:0] DEPTH_STD = 13'h0100;
  localparam logic [CNT_W-1:0] DEPTH_FALL_THROUGH_MODE = 13'h0101;
  localparam logic [CNT_W-1:0] HALF_DEPTH = 13'h0080;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 8'hff;

  // Register map (byte addresses)
  localparam logic [REG_AW-1:0] REG_EMPTY_OFFS = 4'h0;
  localparam logic [REG_AW-1:0] REG_FULL_OFFS = 4'h4;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;
  localparam logic [REG_AW-1:0] REG_MODE = 4'hc;

  // Status register fields
  localparam int ST_EMPTY = 0;
  localparam int ST_FULL = 1;
  localparam int ST_AEMPTY = 2;
  localparam int ST_AFULL = 3;
  localparam int ST_HALF = 4;
  localparam int ST_CNT_LSB = 16;

  // Mode register fields
  localparam int MD_CODE_LSB = 0;
  localparam int MD_TIMING_LSB = 4;

  typedef enum logic [1:0] {
    TM_STD_SINGLE = 2'b00,
    TM_STD_DOUBLE = 2'b01,
    TM_FALL_THROUGH_MODE = 2'b10
  } timing_t;
endpackage : fifo_flags_pkg

// File: core/dual_clock_fifo_status_flags.sv
// One 18-bit FIFO bank with status flags, expansion outputs and registers
// Function
// - Standard mode: empty flag low when no words, high when one stored.
// - Fall-through: output-ready goes low as first word appears on outputs.
// - Fall-through: output-ready rises only on true read after last word.
// - Empty/output-ready output registered, changes only on read edges.
// - Standard: almost-full low after depth minus m writes.
// - Fall-through: almost-full low after depth plus one minus m writes.
// - Async almost-full style: low on write edge, high on read edge.
// - Sync almost-full style changes only on write edges.
// - Almost-empty low at count at most n, or n+1 in fall-through.
// - Async almost-empty style: low on read edge, high on write edge.
// - Sync almost-empty style changes only on read edges.
// - Single-device use: write chain output carries the half-full flag.
// - Half-full low after write passing half, high on a read edge.
// - Daisy chain: write chain output pulses on last location written.
// - Daisy chain: read chain output pulses on last location read.
// - Read data is presented on an 18-bit output word.
// - After reset outputs read zero; driven only with output enable low.
// - Codes 000, 011, 100, 111 select standard single-buffered flags.
// - Single-buffered: first word readable the cycle after empty rises.
// - Write too near a read edge may defer empty deassertion one edge.
// - Read too near a write edge may defer full deassertion one edge.
// - Codes 001 or 101 select fall-through timing with output-ready.
// - Codes 010 or 110 select double register-buffered flags.
// - Two 12-bit offsets, empty then full, loaded alternately via load.
// - Read enable ignored while empty; pointers stay unchanged.
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dual_clock_fifo_status_flags (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic writeClk,
  input wire logic readClk,
  input wire logic writeEnN,
  input wire logic readEnN,
  input wire logic loadSelectN,
  input wire logic outputEnN,
  input wire logic firstLoadN,
  input wire logic readChainIn,
  input wire logic writeChainIn,
  input wire logic [fifo_flags_pkg::DATA_W-1:0] dataIn,
  input wire logic [fifo_flags_pkg::REG_AW-1:0] regAddr,
  input wire logic [fifo_flags_pkg::REG_DW-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [fifo_flags_pkg::REG_DW-1:0] regRdata,
  output logic [fifo_flags_pkg::DATA_W-1:0] dataOut,
  output logic dataOutEn,
  output logic emptyFlagN,
  output logic fullFlagN,
  output logic almostFullN,
  output logic almostEmptyN,
  output logic writeChainOut,
  output logic readChainOut
);
  localparam int CW = fifo_flags_pkg::CNT_W;
  localparam int PW = fifo_flags_pkg::PTR_W;
  localparam int AW = fifo_flags_pkg::ADDR_W;
  localparam int OW = fifo_flags_pkg::OFFS_W;

  function automatic fifo_flags_pkg::timing_t timingOf(
    input logic [2:0] code);
    unique case (code)
      3'h1, 3'h5: timingOf = fifo_flags_pkg::TM_FALL_THROUGH_MODE;
      3'h2, 3'h6: timingOf = fifo_flags_pkg::TM_STD_DOUBLE;
      default: timingOf = fifo_flags_pkg::TM_STD_SINGLE;
    endcase
  endfunction : timingOf

  function automatic logic codeIsAsync(input logic [2:0] code);
    codeIsAsync = (code != 3'h4) && (code != 3'h5) && (code != 3'h6);
  endfunction : codeIsAsync

  function automatic logic codeIsDaisy(input logic [2:0] code);
    codeIsDaisy = (code == 3'h3) || (code == 3'h7);
  endfunction : codeIsDaisy

  logic [2:0] modeCode_q;
  fifo_flags_pkg::timing_t timing;
  logic fall_through_mode, dbl, asyncStyle, daisy;
  logic writeClk_q, readClk_q, wEdge, rEdge;
  logic [PW-1:0] wptr_q, rptr_q, rptrS1_q, rptrS2_q, wptrS1_q, wptrS2_q;
  logic outValidS1_q, outValidS2_q;
  logic [fifo_flags_pkg::DATA_W-1:0] mem [0:fifo_flags_pkg::DEPTH-1];
  logic [OW-1:0] emptyOffs_q, fullOffs_q;
  logic loadSel_q, readSel_q;
  logic fullRaw_q, fullDbl_q, emptyRaw_q, emptyDbl_q, outValid_q;
  logic half_q;
  logic [PW-1:0] wDiff, rDiff;
  logic fullSel, emptySel, doWrite, doStdRead, fwLoad, fwDrain, memRead;
  logic memAvail, outValid_d;
  logic [CW-1:0] wCntNext, rCntNext, wTotal, rTotal;
  logic fullRaw_d, fullDbl_d, emptyRaw_d, emptyDbl_d;
  logic almostFull_d, almostEmpty_d, half_d;

  assign timing = timingOf(modeCode_q);
  assign fall_through_mode = (timing == fifo_flags_pkg::TM_FALL_THROUGH_MODE);
  assign dbl = (timing == fifo_flags_pkg::TM_STD_DOUBLE);
  assign asyncStyle = codeIsAsync(modeCode_q);
  assign daisy = codeIsDaisy(modeCode_q);

  // Mode straps caught while reset is held, then frozen
  // strap capture
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      modeCode_q <= {firstLoadN, readChainIn, writeChainIn};
    end
  end

  // Side clocks arrive synchronous; their rising edges become enables
  // Not reset: a pin already high at release must not look like an edge
  always_ff @(posedge mclk) begin
    writeClk_q <= writeClk;
    readClk_q <= readClk;
  end
  assign wEdge = writeClk & ~writeClk_q;
  assign rEdge = readClk & ~readClk_q;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rptrS1_q <= '0;
      rptrS2_q <= '0;
      wptrS1_q <= '0;
      wptrS2_q <= '0;
      outValidS1_q <= 1'b0;
      outValidS2_q <= 1'b0;
    end else begin
      rptrS1_q <= rptr_q;
      rptrS2_q <= rptrS1_q;
      wptrS1_q <= wptr_q;
      wptrS2_q <= wptrS1_q;
      outValidS1_q <= outValid_q;
      outValidS2_q <= outValidS1_q;
    end
  end

  // Write side view of occupancy
  assign wDiff = wptr_q - rptrS2_q;
  assign fullSel = fullRaw_q | (dbl & fullDbl_q);
  assign doWrite = wEdge & ~writeEnN & loadSelectN & ~fullSel;
  assign wCntNext = CW'(wDiff) + CW'(doWrite);
  assign wTotal = wCntNext + (fall_through_mode ? CW'(outValidS2_q) : '0);
  // stale read pointer may hold full one edge longer
  assign fullRaw_d = wEdge ? (wCntNext == fifo_flags_pkg::DEPTH_STD)
                           : fullRaw_q;
  assign fullDbl_d = wEdge ? fullRaw_q : fullDbl_q;

  // Read side view of occupancy
  assign rDiff = wptrS2_q - rptr_q;
  assign memAvail = (rDiff != '0);
  assign emptySel = emptyRaw_q | (dbl & emptyDbl_q);
  assign doStdRead = rEdge & ~readEnN & loadSelectN & ~emptySel & ~fall_through_mode;
  // first word falls through to the outputs
  assign fwLoad = rEdge & loadSelectN & fall_through_mode & memAvail &
                  (~outValid_q | ~readEnN);
  // true read of the last word clears output-ready
  assign fwDrain = rEdge & loadSelectN & fall_through_mode & outValid_q & ~readEnN &
                   ~memAvail;
  assign memRead = doStdRead | fwLoad;
  assign outValid_d = fwLoad ? 1'b1 : (fwDrain ? 1'b0 : outValid_q);
  assign rCntNext = CW'(rDiff) - CW'(memRead);
  assign rTotal = rCntNext + (fall_through_mode ? CW'(outValid_d) : '0);
  // stale write pointer may hold empty one edge longer
  assign emptyRaw_d = rEdge ? (rCntNext == '0) : emptyRaw_q;
  assign emptyDbl_d = rEdge ? emptyRaw_q : emptyDbl_q;

  function automatic logic fullHit(input logic [CW-1:0] total,
                                   input logic [OW-1:0] offs,
                                   input logic ft);
    // standard threshold; one more word in fall-through
    fullHit = (total + CW'(offs)) >= (ft ? fifo_flags_pkg::DEPTH_FALL_THROUGH_MODE
                                         : fifo_flags_pkg::DEPTH_STD);
  endfunction : fullHit

  function automatic logic emptyHit(input logic [CW-1:0] total,
                                    input logic [OW-1:0] offs,
                                    input logic ft);
    // at most n, or n+1 in fall-through
    emptyHit = total <= (CW'(offs) + CW'(ft));
  endfunction : emptyHit

  always_comb begin
    almostFull_d = almostFullN;
    if (asyncStyle) begin
      // low on write edge, high on read edge
      if (wEdge && fullHit(wTotal, fullOffs_q, fall_through_mode)) begin
        almostFull_d = 1'b0;
      end else if (rEdge && !fullHit(rTotal, fullOffs_q, fall_through_mode)) begin
        almostFull_d = 1'b1;
      end
    end else if (wEdge) begin
      almostFull_d = ~fullHit(wTotal, fullOffs_q, fall_through_mode);
    end
  end

  always_comb begin
    almostEmpty_d = almostEmptyN;
    if (asyncStyle) begin
      // low on read edge, high on write edge
      if (rEdge && emptyHit(rTotal, emptyOffs_q, fall_through_mode)) begin
        almostEmpty_d = 1'b0;
      end else if (wEdge && !emptyHit(wTotal, emptyOffs_q, fall_through_mode)) begin
        almostEmpty_d = 1'b1;
      end
    end else if (rEdge) begin
      almostEmpty_d = ~emptyHit(rTotal, emptyOffs_q, fall_through_mode);
    end
  end

  always_comb begin
    half_d = half_q;
    // set past half on write, released on read
    if (wEdge && (wTotal > fifo_flags_pkg::HALF_DEPTH)) begin
      half_d = 1'b0;
    end else if (rEdge && (rTotal <= fifo_flags_pkg::HALF_DEPTH)) begin
      half_d = 1'b1;
    end
  end

  // Storage and pointers
  always_ff @(posedge mclk) begin
    if (doWrite) begin
      mem[wptr_q[AW-1:0]] <= dataIn;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      if (doWrite) begin
        wptr_q <= wptr_q + PW'(1);
      end
      if (memRead) begin
        rptr_q <= rptr_q + PW'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fullRaw_q <= 1'b0;
      fullDbl_q <= 1'b0;
      emptyRaw_q <= 1'b1;
      emptyDbl_q <= 1'b1;
      outValid_q <= 1'b0;
      half_q <= 1'b1;
    end else begin
      fullRaw_q <= fullRaw_d;
      fullDbl_q <= fullDbl_d;
      emptyRaw_q <= emptyRaw_d;
      emptyDbl_q <= emptyDbl_d;
      outValid_q <= outValid_d;
      half_q <= half_d;
    end
  end

  // Flag pins follow state that only moves on the owning edge
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      emptyFlagN <= 1'b0;
      fullFlagN <= 1'b1;
      almostFullN <= 1'b1;
      almostEmptyN <= 1'b0;
    end else begin
      // empty flag; registered on read edges
      // double buffering delays only the release
      emptyFlagN <= fall_through_mode ? ~outValid_d
                         : ~(emptyRaw_d | (dbl & emptyDbl_d));
      // Input-ready reads high when full in fall-through
      fullFlagN <= fall_through_mode ? fullRaw_d : ~(fullRaw_d | (dbl & fullDbl_d));
      almostFullN <= almostFull_d;
      almostEmptyN <= almostEmpty_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      writeChainOut <= 1'b1;
      readChainOut <= 1'b1;
    end else begin
      // half-full on this pin outside daisy chain
      // low pulse on write of last location
      writeChainOut <= daisy ? ~(doWrite & (wptr_q[AW-1:0] ==
                                 fifo_flags_pkg::LAST_ADDR)) : half_d;
      // low pulse on read of last location
      readChainOut <= ~(daisy & memRead &
                        (rptr_q[AW-1:0] == fifo_flags_pkg::LAST_ADDR));
    end
  end

  // Offsets: pin loading alternates empty then full; bus may also write
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      emptyOffs_q <= fifo_flags_pkg::EMPTY_OFFS_RST;
      fullOffs_q <= fifo_flags_pkg::FULL_OFFS_RST;
      loadSel_q <= 1'b0;
    end else if (wEdge && !loadSelectN && !writeEnN) begin
      if (loadSel_q) begin
        fullOffs_q <= dataIn[OW-1:0];
      end else begin
        emptyOffs_q <= dataIn[OW-1:0];
      end
      loadSel_q <= ~loadSel_q;
    end else if (regWrite) begin
      if (regAddr == fifo_flags_pkg::REG_EMPTY_OFFS) begin
        emptyOffs_q <= regWdata[OW-1:0];
      end
      if (regAddr == fifo_flags_pkg::REG_FULL_OFFS) begin
        fullOffs_q <= regWdata[OW-1:0];
      end
    end
  end

  // Output register holds last word; offsets readable in standard only
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dataOut <= '0;
      dataOutEn <= 1'b0;
      readSel_q <= 1'b0;
    end else begin
      dataOutEn <= ~outputEnN;
      if (memRead) begin
        // 18-bit read word; valid after empty rises
        dataOut <= mem[rptr_q[AW-1:0]];
      end else if (rEdge && !loadSelectN && !readEnN && !fall_through_mode) begin
        dataOut <= (fifo_flags_pkg::DATA_W)'(readSel_q ? fullOffs_q
                                                       : emptyOffs_q);
        readSel_q <= ~readSel_q;
      end
    end
  end

  // Register read port, data valid the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      regRdata <= '0;
    end else if (regRead) begin
      regRdata <= '0;
      unique case (regAddr)
        fifo_flags_pkg::REG_EMPTY_OFFS: regRdata[OW-1:0] <= emptyOffs_q;
        fifo_flags_pkg::REG_FULL_OFFS: regRdata[OW-1:0] <= fullOffs_q;
        fifo_flags_pkg::REG_STATUS: begin
          regRdata[fifo_flags_pkg::ST_EMPTY] <= emptyFlagN;
          regRdata[fifo_flags_pkg::ST_FULL] <= fullFlagN;
          regRdata[fifo_flags_pkg::ST_AEMPTY] <= almostEmptyN;
          regRdata[fifo_flags_pkg::ST_AFULL] <= almostFullN;
          regRdata[fifo_flags_pkg::ST_HALF] <= half_q;
          regRdata[fifo_flags_pkg::ST_CNT_LSB +: PW] <= wDiff;
        end
        fifo_flags_pkg::REG_MODE: begin
          regRdata[fifo_flags_pkg::MD_CODE_LSB +: 3] <= modeCode_q;
          regRdata[fifo_flags_pkg::MD_TIMING_LSB +: 2] <= timing;
        end
        default: regRdata <= '0;
      endcase
    end
  end
endmodule : dual_clock_fifo_status_flags
`default_nettype wire

// File: tb/dual_clock_fifo_status_flags_monitor.sv
// Port checker for the FIFO status-flag bank, bound into the top module
`timescale 1ns/10ps
`default_nettype none
module fifo_flags_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic writeClk,
  input wire logic readClk,
  input wire logic outputEnN,
  input wire logic firstLoadN,
  input wire logic readChainIn,
  input wire logic writeChainIn,
  input wire logic dataOutEn,
  input wire logic emptyFlagN,
  input wire logic almostFullN,
  input wire logic almostEmptyN,
  input wire logic writeChainOut,
  input wire logic readChainOut
);
  logic wPrev, rPrev, wEdge, rEdge, sync, daisy, ok;
  logic [1:0] relCnt;
  always_ff @(posedge mclk) begin
    wPrev <= writeClk;
    rPrev <= readClk;
  end
  // Fall_through_mode pins settle one cycle after release; keep that out of view
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      relCnt <= 2'h0;
    end else if (relCnt != 2'h3) begin
      relCnt <= relCnt + 2'h1;
    end
  end
  assign wEdge = writeClk & ~wPrev;
  assign rEdge = readClk & ~rPrev;
  assign sync = firstLoadN & ~(readChainIn & writeChainIn);
  assign daisy = readChainIn & writeChainIn;
  assign ok = relCnt == 2'h3;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_ef_read_edge: assert property (
    ok && $changed(emptyFlagN) |-> $past(rEdge))
    else $error("empty flag moved away from a read edge");
  chk_af_sync_edge: assert property (
    ok && sync && $changed(almostFullN) |-> $past(wEdge))
    else $error("sync almost-full moved away from a write edge");
  chk_ae_sync_edge: assert property (
    ok && sync && $changed(almostEmptyN) |-> $past(rEdge))
    else $error("sync almost-empty moved away from a read edge");
  chk_af_async_set: assert property (
    ok && !sync && $fell(almostFullN) |-> $past(wEdge))
    else $error("async almost-full set without a write edge");
  chk_af_async_clear: assert property (
    ok && !sync && $rose(almostFullN) |-> $past(rEdge))
    else $error("async almost-full cleared without a read edge");
  chk_ae_async_set: assert property (
    ok && !sync && $fell(almostEmptyN) |-> $past(rEdge))
    else $error("async almost-empty set without a read edge");
  chk_ae_async_clear: assert property (
    ok && !sync && $rose(almostEmptyN) |-> $past(wEdge))
    else $error("async almost-empty cleared without a write edge");
  chk_half_clear: assert property (
    ok && !daisy && $rose(writeChainOut) |-> $past(rEdge))
    else $error("half-full cleared without a read edge");
  chk_wchain_pulse: assert property (
    ok && daisy && $fell(writeChainOut) |-> $past(wEdge) ##1 writeChainOut)
    else $error("write chain pulse malformed");
  chk_rchain_pulse: assert property (
    ok && $fell(readChainOut) |-> $past(rEdge) ##1 readChainOut)
    else $error("read chain pulse malformed");
  chk_oe_follow: assert property (
    ok |-> dataOutEn == !$past(outputEnN))
    else $error("output drive does not follow enable");
endmodule : fifo_flags_checker
bind dual_clock_fifo_status_flags fifo_flags_checker chk_i (
  .mclk(mclk), .nrst(nrst), .writeClk(writeClk), .readClk(readClk),
  .outputEnN(outputEnN), .firstLoadN(firstLoadN),
  .readChainIn(readChainIn), .writeChainIn(writeChainIn),
  .dataOutEn(dataOutEn), .emptyFlagN(emptyFlagN),
  .almostFullN(almostFullN), .almostEmptyN(almostEmptyN),
  .writeChainOut(writeChainOut), .readChainOut(readChainOut));
`default_nettype wire

// File: tb/fifo_side_clocks.sv
// Controller-side model: free-running side clocks and mode straps
`timescale 1ns/10ps
`default_nettype none
module fifo_side_clocks (
  input wire logic mclk,
  input wire logic slow,
  input wire logic [2:0] code,
  output logic writeClk,
  output logic readClk,
  output logic firstLoadN,
  output logic readChainIn,
  output logic writeChainIn
);
  int wc = 0;
  int rc = 0;
  initial writeClk = 1'b0;
  initial readClk = 1'b0;
  // Unequal half periods keep the two sides drifting in phase
  always @(posedge mclk) begin
    wc <= (wc == 2) ? 0 : wc + 1;
    if (wc == 2) begin
      writeClk <= ~writeClk;
    end
    rc <= (rc >= (slow ? 8 : 3)) ? 0 : rc + 1;
    if (rc >= (slow ? 8 : 3)) begin
      readClk <= ~readClk;
    end
  end
  assign {firstLoadN, readChainIn, writeChainIn} = code;
endmodule : fifo_side_clocks
`default_nettype wire

// File: tb/dual_clock_fifo_status_flags_tb.sv
// Self-checking bench for the FIFO status-flag bank
`timescale 1ns/10ps
`default_nettype none
module dual_clock_fifo_status_flags_tb;
  logic mclk = 1'b0, nrst = 1'b0, writeEnN = 1'b1, readEnN = 1'b1;
  logic loadSelectN = 1'b1, outputEnN = 1'b0, slow = 1'b0;
  logic regWrite = 1'b0, regRead = 1'b0;
  logic [2:0] code = 3'h0;
  logic [fifo_flags_pkg::DATA_W-1:0] dataIn = 18'h00000, dataOut, last;
  logic [fifo_flags_pkg::REG_AW-1:0] regAddr = 4'h0;
  logic [fifo_flags_pkg::REG_DW-1:0] regWdata = 32'h0, regRdata, rv;
  logic writeClk, readClk, firstLoadN, readChainIn, writeChainIn;
  logic dataOutEn, emptyFlagN, fullFlagN, almostFullN, almostEmptyN;
  logic writeChainOut, readChainOut, wcPrev = 1'b1, rcPrev = 1'b1;
  logic [17:0] q[$];
  int error_cnt = 0, n_compared = 0, wPulses, rPulses, dep, st, n, m;
  bit fw, daisy;
  always #20 mclk = ~mclk;
  fifo_side_clocks ctrl (.mclk(mclk), .slow(slow), .code(code),
    .writeClk(writeClk), .readClk(readClk), .firstLoadN(firstLoadN),
    .readChainIn(readChainIn), .writeChainIn(writeChainIn));
  dual_clock_fifo_status_flags dut (.mclk(mclk), .nrst(nrst),
    .writeClk(writeClk), .readClk(readClk), .writeEnN(writeEnN),
    .readEnN(readEnN), .loadSelectN(loadSelectN), .outputEnN(outputEnN),
    .firstLoadN(firstLoadN), .readChainIn(readChainIn),
    .writeChainIn(writeChainIn), .dataIn(dataIn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN),
    .almostFullN(almostFullN), .almostEmptyN(almostEmptyN),
    .writeChainOut(writeChainOut), .readChainOut(readChainOut));
  always @(posedge mclk) begin
    wcPrev <= writeChainOut;
    rcPrev <= readChainOut;
    if (nrst && daisy && wcPrev && !writeChainOut) wPulses++;
    if (nrst && daisy && rcPrev && !readChainOut) rPulses++;
  end
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(bit wr, logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= wr;
    regRead <= !wr;
    @(posedge mclk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    @(posedge mclk);
    rv = regRdata;
  endtask : bus
  task automatic flags();
    int s;
    s = q.size();
    repeat (st) @(posedge mclk);
    chk("empty flag", fw ? s == 0 : s != 0, emptyFlagN);
    chk("full flag", fw ? s == dep : s != dep, fullFlagN);
    chk("almost full", s < dep - m, almostFullN);
    chk("almost empty", s > n + fw, almostEmptyN);
    chk("half full", daisy || s <= 128, writeChainOut);
    chk("data", (fw && s != 0) ? q[0] : last, dataOut);
  endtask : flags
  task automatic wr(logic [17:0] d);
    @(posedge mclk iff !writeClk);
    writeEnN <= 1'b0;
    dataIn <= d;
    @(posedge mclk iff writeClk);
    @(posedge mclk iff !writeClk);
    writeEnN <= 1'b1;
    if (q.size() < dep) q.push_back(d);
    flags();
  endtask : wr
  task automatic rd();
    @(posedge mclk iff !readClk);
    readEnN <= 1'b0;
    @(posedge mclk iff readClk);
    @(posedge mclk iff !readClk);
    readEnN <= 1'b1;
    if (q.size() != 0) last = q.pop_front();
    flags();
  endtask : rd
  // Offset load through the pins: one write edge with load and enable low
  task automatic ld(logic [17:0] d);
    @(posedge mclk iff !writeClk);
    loadSelectN <= 1'b0;
    writeEnN <= 1'b0;
    dataIn <= d;
    @(posedge mclk iff writeClk);
    @(posedge mclk iff !writeClk);
    writeEnN <= 1'b1;
    loadSelectN <= 1'b1;
  endtask : ld
  task automatic run(logic [2:0] c, int cnt);
    @(posedge mclk);
    code <= c;
    nrst <= 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    fw = c == 3'h1 || c == 3'h5;
    daisy = c == 3'h3 || c == 3'h7;
    dep = fw ? 257 : 256;
    q.delete();
    last = '0;
    wPulses = 0;
    rPulses = 0;
    bus(0, 4'h8, 0);
    chk("status", fw ? 5'h19 : 5'h1a, rv[4:0]);
    chk("reset data", 0, dataOut);
    bus(1, 4'hc, 32'hffffffff);
    bus(0, 4'hc, 0);
    chk("mode code", c, rv[2:0]);
    chk("timing", fw ? 2 : (c[1] && !c[0]) ? 1 : 0, rv[5:4]);
    n = 3;
    m = 4;
    // Pin loading alternates empty, then full
    ld(18'h00005);
    ld(18'h00007);
    bus(0, 4'h0, 0);
    chk("empty offset pin", 5, rv);
    bus(0, 4'h4, 0);
    chk("full offset pin", 7, rv);
    bus(1, 4'h0, n);
    bus(1, 4'h4, m);
    bus(0, 4'h4, 0);
    chk("full offset", m, rv);
    bus(0, 4'h2, 0);
    chk("unmapped read", 0, rv);
    for (int i = 0; i < cnt; i++) wr(18'($urandom()));
    // One read more than written (two more than stored when full drops a write); the extra reads must be ignored
    for (int i = 0; i <= cnt; i++) rd();
  endtask : run
  initial begin
    void'($urandom(27));
    st = 24;
    run(3'h0, 257);
    run(3'h3, 257);
    chk("write pulses", 1, wPulses);
    chk("read pulses", 1, rPulses);
    run(3'h6, 257);
    slow <= 1'b1;
    st = 80;
    run(3'h5, 5);
    outputEnN <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("output drive", 0, dataOutEn);
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    end_of_test();
  end
endmodule : dual_clock_fifo_status_flags_tb
`default_nettype wire
